// ---- hw/ctc_pkg.sv ----
// Constants and carrier types of the capacitive-sense threshold comparator
// Notes on behaviour
// - Final result above threshold sets flag, else clears
// - Compare only after last accumulated conversion
// - Flag set with enable raises an interrupt
// - Flag set pauses auto-scan until busy written
// - Suspend with scanning lasts until greater event
// - Greater event wakes regardless of interrupt enable
package ctc_pkg;
  localparam int unsigned AXI_AW = 8;
  localparam int unsigned AXI_DW = 32;
  localparam logic [AXI_AW-1:0] OFS_CTRL   = 8'h00;
  localparam logic [AXI_AW-1:0] OFS_THR_LO = 8'h04;
  localparam logic [AXI_AW-1:0] OFS_THR_HI = 8'h08;
  localparam logic [AXI_AW-1:0] OFS_ACC    = 8'h0c;
  localparam logic [AXI_AW-1:0] OFS_RESULT = 8'h10;
  localparam logic [AXI_AW-1:0] OFS_INT_ST = 8'h14;
  localparam logic [AXI_AW-1:0] OFS_INT_MK = 8'h18;
  // Control register bits
  localparam int unsigned CTRL_GT   = 0;
  localparam int unsigned CTRL_SCAN = 1;
  localparam int unsigned CTRL_BUSY = 2;
  localparam int unsigned CTRL_SUSP = 3;
  // Interrupt status and mask bits
  localparam int unsigned INT_GT    = 0;
  localparam int unsigned INT_DONE  = 1;
  localparam int unsigned INT_W     = 2;
  localparam int unsigned ACC_SEL_W = 3;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    CTC_RUN  = 2'h0,
    CTC_SUSP = 2'h1,
    CTC_WAKE = 2'h3
  } ctc_pwr_t;

  typedef struct packed {
    logic [AXI_AW-1:0] awaddr;
    logic              awvalid;
    logic [AXI_DW-1:0] wdata;
    logic [3:0]        wstrb;
    logic              wvalid;
    logic              bready;
    logic [AXI_AW-1:0] araddr;
    logic              arvalid;
    logic              rready;
  } ctc_axi_req_t;

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic [1:0]        bresp;
    logic              bvalid;
    logic              arready;
    logic [AXI_DW-1:0] rdata;
    logic [1:0]        rresp;
    logic              rvalid;
  } ctc_axi_rsp_t;
endpackage

// ---- hw/ctc_top.sv ----
// Threshold comparator with AXI4-Lite registers, scan pause and wake
`timescale 1ns/100ps
`default_nettype none
module ctc_top
  import ctc_pkg::*;
#(
  parameter int unsigned DATA_W    = 16,
  parameter int unsigned ACC_LOG2M = 6
)(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire ctc_axi_req_t      axi_req,
  output var  ctc_axi_rsp_t      axi_rsp,
  input  wire logic              conv_valid,
  input  wire logic [DATA_W-1:0] conv_result,
  output logic                   scan_permit,
  output logic                   suspended,
  output logic                   wake,
  output logic                   irq
);
  localparam int unsigned ACC_W = DATA_W + ACC_LOG2M;

  if (DATA_W != 16 || ACC_LOG2M < 1 || ACC_LOG2M > 7)
  begin : g_bad
    $error("ctc_top: unsupported parameters");
  end

  typedef struct packed {
    ctc_axi_rsp_t            rsp;
    logic                    aw_have;
    logic [AXI_AW-1:0]       aw_addr;
    logic                    w_have;
    logic [AXI_DW-1:0]       w_data;
    logic [3:0]              w_strb;
    logic [7:0]              thr_lo;
    logic [7:0]              thr_hi;
    logic [ACC_SEL_W-1:0]    acc_sel;
    logic [ACC_W-1:0]        acc;
    logic [ACC_LOG2M-1:0]    cnt;
    logic [DATA_W-1:0]       result;
    logic                    gt_flag;
    logic                    scan_en;
    logic                    scan_hold;
    logic                    scan_permit;
    ctc_pwr_t                pwr;
    logic                    susp;
    logic                    wake;
    logic [INT_W-1:0]        int_st;
    logic [INT_W-1:0]        int_mk;
    logic                    irq;
  } ctc_state_t;

  ctc_state_t        s_q;
  ctc_state_t        s_d;
  logic [DATA_W-1:0] thr;
  logic [ACC_LOG2M-1:0] last_cnt;
  logic [ACC_W-1:0]  sum;
  logic [DATA_W-1:0] avg;
  logic              fin;
  logic              gt_ev;
  logic              wr_go;
  logic              wr_ctrl_busy;

  // ----------------------------------------
  // Comparator datapath
  // ----------------------------------------
  assign thr      = {s_q.thr_hi, s_q.thr_lo};
  assign last_cnt = ACC_LOG2M'((1 << s_q.acc_sel) - 1);
  assign sum      = s_q.acc + ACC_W'(conv_result);
  assign avg      = DATA_W'(sum >> s_q.acc_sel);
  assign fin      = conv_valid && (s_q.cnt == last_cnt);
  assign gt_ev    = fin && (avg > thr);
  assign wr_go    = s_q.aw_have && s_q.w_have && !s_q.rsp.bvalid;
  assign wr_ctrl_busy = wr_go && (s_q.aw_addr == OFS_CTRL)
                        && s_q.w_strb[0] && s_q.w_data[CTRL_BUSY];

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    s_d      = s_q;
    s_d.wake = 1'b0;
    // Bus handshakes, address and data taken in either order
    if (axi_req.awvalid && s_q.rsp.awready)
    begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && s_q.rsp.wready)
    begin
      s_d.w_have = 1'b1;
      s_d.w_data = axi_req.wdata;
      s_d.w_strb = axi_req.wstrb;
    end
    if (s_q.rsp.bvalid && axi_req.bready)
      s_d.rsp.bvalid = 1'b0;
    if (wr_go)
    begin
      s_d.aw_have    = 1'b0;
      s_d.w_have     = 1'b0;
      s_d.rsp.bvalid = 1'b1;
      s_d.rsp.bresp  = RESP_OKAY;
      unique case (s_q.aw_addr)
        OFS_CTRL:
          if (s_q.w_strb[0])
          begin
            s_d.scan_en = s_q.w_data[CTRL_SCAN];
            if (s_q.w_data[CTRL_BUSY])
              s_d.scan_hold = 1'b0;
            if (s_q.w_data[CTRL_SUSP] && s_q.w_data[CTRL_SCAN]
                && s_q.pwr == CTC_RUN)
              s_d.pwr = CTC_SUSP;
          end
        OFS_THR_LO:
          if (s_q.w_strb[0]) s_d.thr_lo = s_q.w_data[7:0];
        OFS_THR_HI:
          if (s_q.w_strb[0]) s_d.thr_hi = s_q.w_data[7:0];
        OFS_ACC:
          if (s_q.w_strb[0])
          begin
            s_d.acc_sel = s_q.w_data[ACC_SEL_W-1:0];
            s_d.acc     = '0;
            s_d.cnt     = '0;
          end
        OFS_INT_ST:
          if (s_q.w_strb[0])
            s_d.int_st = s_q.int_st & ~s_q.w_data[INT_W-1:0];
        OFS_INT_MK:
          if (s_q.w_strb[0]) s_d.int_mk = s_q.w_data[INT_W-1:0];
        OFS_RESULT: ;
        default: s_d.rsp.bresp = RESP_SLVERR;
      endcase
    end
    if (s_q.rsp.rvalid && axi_req.rready)
      s_d.rsp.rvalid = 1'b0;
    if (axi_req.arvalid && s_q.rsp.arready)
    begin
      s_d.rsp.rvalid = 1'b1;
      s_d.rsp.rresp  = RESP_OKAY;
      s_d.rsp.rdata  = '0;
      unique case (axi_req.araddr)
        OFS_CTRL:
        begin
          s_d.rsp.rdata[CTRL_GT]   = s_q.gt_flag;
          s_d.rsp.rdata[CTRL_SCAN] = s_q.scan_en;
          s_d.rsp.rdata[CTRL_BUSY] = s_q.scan_permit;
          s_d.rsp.rdata[CTRL_SUSP] = (s_q.pwr != CTC_RUN);
        end
        OFS_THR_LO: s_d.rsp.rdata[7:0]          = s_q.thr_lo;
        OFS_THR_HI: s_d.rsp.rdata[7:0]          = s_q.thr_hi;
        OFS_ACC:    s_d.rsp.rdata[ACC_SEL_W-1:0] = s_q.acc_sel;
        OFS_RESULT: s_d.rsp.rdata[DATA_W-1:0]   = s_q.result;
        OFS_INT_ST: s_d.rsp.rdata[INT_W-1:0]    = s_q.int_st;
        OFS_INT_MK: s_d.rsp.rdata[INT_W-1:0]    = s_q.int_mk;
        default:    s_d.rsp.rresp               = RESP_SLVERR;
      endcase
    end
    // Accumulate and compare
    if (conv_valid)
    begin
      if (fin)
      begin
        s_d.acc     = '0;
        s_d.cnt     = '0;
        s_d.result  = avg;
        s_d.gt_flag = gt_ev;
        s_d.int_st[INT_DONE] = 1'b1;
      end
      else
      begin
        s_d.acc = sum;
        s_d.cnt = s_q.cnt + 1'b1;
      end
    end
    // Events win over a simultaneous clear
    if (gt_ev)
    begin
      s_d.int_st[INT_GT] = 1'b1;
      if (s_q.scan_en || s_d.scan_en)
        s_d.scan_hold = 1'b1;
    end
    // Suspend and wake, mask not consulted
    unique case (s_q.pwr)
      CTC_RUN: ;
      CTC_SUSP:
        if (gt_ev)
        begin
          s_d.pwr  = CTC_WAKE;
          s_d.wake = 1'b1;
        end
      CTC_WAKE: s_d.pwr = CTC_RUN;
      default:  s_d.pwr = CTC_RUN;
    endcase
    s_d.scan_permit = s_d.scan_en && !s_d.scan_hold;
    s_d.irq         = |(s_d.int_st & s_d.int_mk);
    s_d.susp        = (s_d.pwr == CTC_SUSP);
    s_d.rsp.awready = !s_d.aw_have && !s_d.rsp.bvalid;
    s_d.rsp.wready  = !s_d.w_have && !s_d.rsp.bvalid;
    s_d.rsp.arready = !s_d.rsp.rvalid;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_q             <= '0;
      s_q.pwr         <= CTC_RUN;
      s_q.rsp.awready <= 1'b1;
      s_q.rsp.wready  <= 1'b1;
      s_q.rsp.arready <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign axi_rsp     = s_q.rsp;
  assign scan_permit = s_q.scan_permit;
  assign suspended   = s_q.susp;
  assign wake        = s_q.wake;
  assign irq         = s_q.irq;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_gt_set;
    @(posedge clk) disable iff (sys_rst)
    fin && (avg > thr) |=> s_q.gt_flag;
  endproperty
  a_gt_set: assert property (p_gt_set)
    else $error("flag not set above threshold");

  property p_gt_clr;
    @(posedge clk) disable iff (sys_rst)
    fin && (avg <= thr) |=> !s_q.gt_flag;
  endproperty
  a_gt_clr: assert property (p_gt_clr)
    else $error("flag not cleared at or below threshold");

  property p_acc_hold;
    @(posedge clk) disable iff (sys_rst)
    conv_valid && !fin |=> $stable(s_q.gt_flag) && $stable(s_q.result);
  endproperty
  a_acc_hold: assert property (p_acc_hold)
    else $error("compare before last accumulated conversion");

  property p_irq;
    @(posedge clk) disable iff (sys_rst)
    gt_ev && s_q.int_mk[INT_GT] |=> irq && s_q.int_st[INT_GT];
  endproperty
  a_irq: assert property (p_irq)
    else $error("no interrupt on enabled greater event");

  property p_scan_pause;
    @(posedge clk) disable iff (sys_rst)
    gt_ev && s_q.scan_en && !wr_go |=> !scan_permit;
  endproperty
  a_scan_pause: assert property (p_scan_pause)
    else $error("scan not paused after greater event");

  property p_resume;
    @(posedge clk) disable iff (sys_rst)
    wr_ctrl_busy && !gt_ev && s_q.w_data[CTRL_SCAN] |=> scan_permit;
  endproperty
  a_resume: assert property (p_resume)
    else $error("busy write did not resume scan");

  sequence s_wake_seq;
    wake && !suspended ##1 !wake && s_q.pwr == CTC_RUN;
  endsequence
  property p_wake;
    @(posedge clk) disable iff (sys_rst)
    suspended && gt_ev |=> s_wake_seq;
  endproperty
  a_wake: assert property (p_wake)
    else $error("greater event did not wake");

  property p_stay;
    @(posedge clk) disable iff (sys_rst)
    suspended && !gt_ev |=> suspended && !wake;
  endproperty
  a_stay: assert property (p_stay)
    else $error("left suspend without greater event");

  property p_wake_nomask;
    @(posedge clk) disable iff (sys_rst)
    suspended && gt_ev && !s_q.int_mk[INT_GT] |=> wake;
  endproperty
  a_wake_nomask: assert property (p_wake_nomask)
    else $error("wake depended on interrupt enable");

  property p_thr;
    @(posedge clk) disable iff (sys_rst)
    wr_go && s_q.aw_addr == OFS_THR_HI && s_q.w_strb[0]
      |=> thr[DATA_W-1 -: 8] == $past(s_q.w_data[7:0]);
  endproperty
  a_thr: assert property (p_thr)
    else $error("high threshold byte not in upper bits");
endmodule
`default_nettype wire

// ---- test/cap_sense_threshold_compare_test.sv ----
// Register-level testbench of the threshold comparator
`timescale 1ns/100ps
`default_nettype none
module cap_sense_threshold_compare_test;
  import ctc_pkg::*;
  logic         clk;
  logic         sys_rst;
  ctc_axi_req_t req;
  ctc_axi_rsp_t rsp;
  logic         conv_valid;
  logic [15:0]  conv_result;
  logic         scan_permit;
  logic         suspended;
  logic         wake;
  logic         irq;
  logic [31:0]  rdat;
  logic [1:0]   w_resp;
  logic [1:0]   r_resp;
  int           n_mismatch;
  int           check_count;

  ctc_top DUT (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .axi_req     (req),
    .axi_rsp     (rsp),
    .conv_valid  (conv_valid),
    .conv_result (conv_result),
    .scan_permit (scan_permit),
    .suspended   (suspended),
    .wake        (wake),
    .irq         (irq)
  );

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
    begin
      $display("*** PASS ***");
    end
    else
    begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req.awaddr  <= a;
    req.awvalid <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= 4'hf;
    req.wvalid  <= 1'b1;
    req.bready  <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid)
      begin
        w_resp = rsp.bresp;
        req.bready <= 1'b0;
        break;
      end
    end
    #1;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    req.araddr  <= a;
    req.arvalid <= 1'b1;
    req.rready  <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid)
      begin
        rdat   = rsp.rdata;
        r_resp = rsp.rresp;
        req.rready <= 1'b0;
        break;
      end
    end
    #1;
  endtask

  task automatic conv(input logic [15:0] v);
    @(posedge clk);
    conv_valid  <= 1'b1;
    conv_result <= v;
    @(posedge clk);
    conv_valid  <= 1'b0;
    #1;
  endtask

  // ------------------------------------------------------------
  // Clock, reset and watchdog
  // ------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial
  begin
    #(40 * 20000);
    n_mismatch++;
    finish_test();
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial
  begin
    n_mismatch  = 0;
    check_count = 0;
    req         = '0;
    conv_valid  = 1'b0;
    conv_result = 16'h0000;
    sys_rst     = 1'b1;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    check(32'(irq), 32'h0);
    check(32'(scan_permit), 32'h0);
    rd(OFS_CTRL); check(rdat, 32'h0);
    rd(8'h1c); check(32'(r_resp), 32'(RESP_SLVERR));
    check(rdat, 32'h0);
    wr(8'h1c, 32'h1); check(32'(w_resp), 32'(RESP_SLVERR));
    wr(OFS_THR_LO, 32'h34);
    check(32'(w_resp), 32'(RESP_OKAY));
    wr(OFS_THR_HI, 32'h12);
    rd(OFS_THR_HI); check(rdat, 32'h12);
    check(32'(r_resp), 32'(RESP_OKAY));
    // Above the joined threshold but below the swapped one
    wr(OFS_INT_MK, 32'h1);
    conv(16'h1300);
    check(32'(irq), 32'h1);
    rd(OFS_CTRL); check(rdat, 32'h1);
    rd(OFS_INT_ST); check(rdat, 32'h3);
    wr(OFS_INT_ST, 32'h3);
    check(32'(irq), 32'h0);
    conv(16'h1234);
    rd(OFS_CTRL); check(rdat, 32'h0);
    check(32'(irq), 32'h0);
    conv(16'h1235);
    rd(OFS_CTRL); check(rdat, 32'h1);
    // Masked greater event sets status but no interrupt
    wr(OFS_INT_MK, 32'h0);
    wr(OFS_INT_ST, 32'h3);
    conv(16'hffff);
    check(32'(irq), 32'h0);
    rd(OFS_INT_ST); check(rdat, 32'h3);
    // Two-conversion accumulation
    conv(16'h0000);
    wr(OFS_ACC, 32'h1);
    conv(16'h2000);
    rd(OFS_CTRL); check(rdat, 32'h0);
    conv(16'h2000);
    rd(OFS_CTRL); check(rdat, 32'h1);
    rd(OFS_RESULT); check(rdat, 32'h2000);
    wr(OFS_ACC, 32'h0);
    // Auto-scan pause and resume
    conv(16'h0000);
    wr(OFS_CTRL, 32'h2);
    check(32'(scan_permit), 32'h1);
    conv(16'h1300);
    check(32'(scan_permit), 32'h0);
    repeat (3) @(posedge clk);
    #1;
    check(32'(scan_permit), 32'h0);
    wr(OFS_CTRL, 32'h6);
    check(32'(scan_permit), 32'h1);
    // Suspend, no wake below threshold, wake with interrupt masked
    wr(OFS_CTRL, 32'ha);
    check(32'(suspended), 32'h1);
    conv(16'h1000);
    repeat (3) @(posedge clk);
    #1;
    check(32'(suspended), 32'h1);
    check(32'(wake), 32'h0);
    conv(16'h1300);
    check(32'(wake), 32'h1);
    check(32'(suspended), 32'h0);
    @(posedge clk);
    #1;
    check(32'(wake), 32'h0);
    check(32'(suspended), 32'h0);
    repeat (2) @(posedge clk);
    rd(OFS_CTRL); check(rdat & 32'h9, 32'h1);
    finish_test();
  end
endmodule
`default_nettype wire
